/* src/port_map_input_combiner.sv */
`timescale 1ns/10ps
module port_map_input_combiner
  import port_map_pkg::*;
(
  input  wire logic                     ref_clk,
  input  wire logic                     resetn,
  input  wire logic [NUM_PINS-1:0]      pin_in,
  input  pin_cfg_s  [NUM_PINS-1:0]      pin_cfg,
  input  wire logic                     remap_reconfig_allow,
  output logic      [NUM_INPUTS-1:0]    module_in
);

  // ----------------------------------------------------------------------
  // pin synchronisers and held levels
  // ----------------------------------------------------------------------
  logic [NUM_PINS-1:0]   sync_a;
  logic [NUM_PINS-1:0]   sync_b;
  logic [NUM_PINS-1:0]   held;
  logic [NUM_PINS-1:0]   sel_q;
  logic [NUM_PINS-1:0]   next_held;
  logic [NUM_PINS-1:0]   next_sel_q;
  logic [NUM_PINS-1:0]   contrib;
  logic [NUM_PINS-1:0]   active;
  logic [NUM_INPUTS-1:0] next_module_in;

  // with reconfig allowed, only the lowest selected pin per input counts
  function automatic logic [NUM_PINS-1:0] first_per_input(
    input pin_cfg_s [NUM_PINS-1:0] cfg
  );
    logic [NUM_INPUTS-1:0] taken;
    logic [NUM_PINS-1:0]   keep;
    taken = '0;
    keep  = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (cfg[p].pin_function_select && !taken[cfg[p].target]) begin
        keep[p]              = 1'b1;
        taken[cfg[p].target] = 1'b1;
      end
    end
    return keep;
  endfunction : first_per_input

  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      next_sel_q[p] = pin_cfg[p].pin_function_select;
      // hold on deselect: freeze the level at the clearing moment
      if (pin_cfg[p].pin_function_select) begin
        next_held[p] = sync_b[p];
      end else if (sel_q[p]) begin
        next_held[p] = sync_b[p];
      end else begin
        next_held[p] = held[p];
      end
    end
  end

  always_comb begin
    active = remap_reconfig_allow ? first_per_input(pin_cfg) : '1;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (pin_cfg[p].pin_function_select) begin
        contrib[p] = sync_b[p] & active[p];
      // reconfig drops stale latch, so only one source feeds
      end else if (remap_reconfig_allow) begin
        contrib[p] = 1'b0;
      // held high sticks: keeps the OR at 1 (silicon behaviour)
      end else begin
        contrib[p] = held[p];
      end
    end
    next_module_in = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (contrib[p]) begin
        next_module_in[pin_cfg[p].target] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sync_a    <= {NUM_PINS{SYNC_RESET}};
      sync_b    <= {NUM_PINS{SYNC_RESET}};
      held      <= {NUM_PINS{HELD_RESET}};
      sel_q     <= '0;
      module_in <= '0;
    end else begin
      sync_a    <= pin_in;
      sync_b    <= sync_a;
      held      <= next_held;
      sel_q     <= next_sel_q;
      module_in <= next_module_in;
    end
  end

endmodule : port_map_input_combiner

/* src/port_map_pkg.sv */
// Summary of operation
// - Each peripheral module input is the OR of every pin input mapped to it while the reconfiguration option is off.
// - Clearing a pin's function select holds its OR contribution at its level while the reconfiguration option is off.
// - A held high level keeps the combined module input at 1 while the reconfiguration option is off.
// - The reconfiguration option lets only one mapped pin feed each input.
package port_map_pkg;

  // ----------------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_PINS    = 8;
  localparam int unsigned NUM_INPUTS  = 4;
  localparam int unsigned MAP_W       = 2;
  localparam logic        HELD_RESET  = 1'b0;
  localparam logic        SYNC_RESET  = 1'b0;

  typedef logic [MAP_W-1:0] map_t;

  // per-pin configuration carried together
  typedef struct packed {
    logic pin_function_select;
    map_t target;
  } pin_cfg_s;

endpackage : port_map_pkg

/* verification/pm_properties.sv */
`timescale 1ns/10ps
module pm_check
  import port_map_pkg::*;
(input wire logic ref_clk, resetn, remap_reconfig_allow,
  input wire logic [7:0] pin_in, input pin_cfg_s [7:0] pin_cfg,
  input wire logic [3:0] module_in);
  // pin history matches the two sync flops plus the output register
  logic [23:0] d;
  logic [2:0] rh;
  wire a = !remap_reconfig_allow, up = &rh;
  wire st = pin_cfg == 24'hFA_CFAC && a, hd = pin_cfg == 24'hFA_CFA8 && a;
  // reconfig on with pin 0 dropped: pin 4 is the only source left for input 0
  wire rc = pin_cfg == 24'hFA_CFA8 && remap_reconfig_allow;
  always_ff @(posedge ref_clk)
    {d, rh} <= {d[15:0], pin_in, rh[1:0], resetn};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  or_path_a: assert property (up && $past(st) |->
    module_in == (d[19:16] | d[23:20])) else $error("or path");
  held_high_a: assert property (up && hd && $past(hd) && !d[20] &&
    module_in[0] |=> module_in[0]) else $error("held level");
  reconfig_one_a: assert property (up && $past(rc) |->
    module_in == {d[19:17], d[20]}) else $error("reconfig source");
  live_rest_a: assert property (up && $past(hd) |->
    module_in[3:1] == (d[19:17] | d[23:21])) else $error("live pins");
  reset_clear_a: assert property (disable iff (1'b0) !resetn |=>
    module_in == 4'h0) else $error("reset clear");
endmodule : pm_check
bind port_map_input_combiner pm_check chk (.*);

/* verification/periph_model.sv */
`timescale 1ns/10ps
module periph_model (input wire logic ref_clk,
  input wire logic [3:0] module_in, output logic [3:0] seen);
  always_ff @(posedge ref_clk) seen <= module_in;
endmodule : periph_model

/* verification/port_map_input_combiner_bench.sv */
`timescale 1ns/10ps
module port_map_input_combiner_bench;
  import port_map_pkg::*;
  logic ref_clk = 0, resetn = 0, allow = 0;
  logic [7:0] pin_in = 0;
  pin_cfg_s [7:0] pin_cfg = 24'hFA_CFAC;
  logic [3:0] module_in, seen, q[$];
  logic [31:0] r = 32'h0001_85B6;
  int n_mismatch = 0, cmp_count = 0, i;
  port_map_input_combiner dut (.*, .remap_reconfig_allow(allow));
  periph_model partner (.*);
  function logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task test_done;
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  task check(logic [3:0] s, x);
    cmp_count++;
    n_mismatch += int'(s !== x);
    if (s !== x) $display("CHECK FAILED module_in exp %h seen %h", x, s);
  endtask : check
  initial forever #2.5 ref_clk = ~ref_clk;
  initial #2000 begin n_mismatch++; test_done; end
  always @(negedge ref_clk) if (q.size() > 4)
    check(seen, q.pop_front());
  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1;
    for (i = 0; i < 120; i++) begin
      @(posedge ref_clk);
      r = lfsr(r);
      // pins 0 and 3 to 7 held steady in the three cycles before each switch keep both rule sets in step
      if (i % 40 > 36) r[7:0] = {5'h03, r[1:0], 1'b1};
      pin_in <= r[7:0];
      // pin 0 left high at deselect
      if (i == 40) pin_cfg <= 24'hFA_CFA8;
      if (i == 80) allow <= 1;
      q.push_back(i < 80 ? r[3:0] | r[7:4] | 4'(i > 39) : {r[3:1], r[4]});
    end
    test_done;
  end
endmodule : port_map_input_combiner_bench
